/* File: core/cache_miss_policy.sv */
// Miss policy, refill way choice and set locking for the two primary caches.
// Assumes the pipeline presents one miss or write-through store at a time,
// with the tag state of the indexed pair, and holds it while req_ready is low.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Uncached access: single read or write only
// - Uncached addresses never allocate a line
// - Cacheable load miss: block read, then fill
// - Write-allocate store miss: fill, then write through
// - No-write-allocate store miss: single memory write
// - Algorithm register: 3-bit attribute per region
// - No hardware coherency, no snooping
// - Only uncached and noncoherent classes valid
// - Locked valid set A never a victim
// - Lock spares maintenance ops, stores, invalid lines
// - Each cache 8KB, two 4KB ways
// - Both lock bits cleared after reset
// - Status bits lock data and instruction set A
// - Both lines invalid: refill set A
// - Invalid locked line refillable, then kept
// - Store hits update locked lines normally
// - Attribute selects write-back or write-through
// - Block fill always marked dirty exclusive
// - Replacement bit picks between eligible ways
module cache_miss_policy (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Status and cache algorithm register writes
   input wire logic sr_we,
   input wire logic [cache_policy_pkg::SR_W-1:0] sr_wdata,
   input wire logic cache_algorithm_register_we,
   input wire logic [cache_policy_pkg::CACHE_ALGORITHM_REGISTER_W-1:0] cache_algorithm_register_wdata,
   // Register state
   output logic data_set_lock_bit,
   output logic instr_set_lock_bit,
   output logic [cache_policy_pkg::CACHE_ALGORITHM_REGISTER_W-1:0] cache_algorithm_register,
   // Request from the pipeline
   input wire logic req_valid,
   input wire logic req_icache,
   input wire logic req_store,
   input wire logic req_hit,
   input wire logic [cache_policy_pkg::REGION_W-1:0] req_region,
   input wire logic [cache_policy_pkg::ADDR_W-1:0] req_addr,
   input wire logic [cache_policy_pkg::SIZE_W-1:0] req_size,
   input wire logic [cache_policy_pkg::DATA_W-1:0] req_wdata,
   input wire logic tag_valid_a,
   input wire logic tag_valid_b,
   input wire logic tag_repl,
   output logic req_ready,
   output logic done,
   output logic [cache_policy_pkg::DATA_W-1:0] done_rdata,
   // System interface requests
   output logic sys_req_valid,
   output cache_policy_pkg::sys_cmd_t sys_req_cmd,
   output logic [cache_policy_pkg::ADDR_W-1:0] sys_req_addr,
   output logic [cache_policy_pkg::SIZE_W-1:0] sys_req_size,
   output logic [cache_policy_pkg::DATA_W-1:0] sys_req_wdata,
   input wire logic sys_req_ack,
   input wire logic sys_resp_valid,
   input wire logic [cache_policy_pkg::DATA_W-1:0] sys_resp_data,
   // Tag write on refill and store merge after allocation
   output logic fill_we,
   output logic fill_icache,
   output logic fill_way_b,
   output logic [cache_policy_pkg::INDEX_W-1:0] fill_index,
   output cache_policy_pkg::line_state_t fill_state,
   output logic fill_repl,
   output logic store_merge_we
);

   typedef enum {ST_IDLE, ST_ISSUE, ST_WAIT, ST_FILL, ST_MERGE, ST_DONE} miss_state_t;

   miss_state_t state;
   miss_state_t next_state;
   logic pend_merge;
   logic pend_wt;
   logic cur_uncached;
   logic victim_b;

   // Attribute decode for the request's region
   wire logic [cache_policy_pkg::ATTR_W-1:0] cur_attr;
   wire logic attr_wb;
   wire logic attr_wt_alloc;
   wire logic attr_wt_noalloc;
   wire logic attr_uncached;
   wire logic accept;
   wire logic need_block;
   wire logic need_single_rd;
   wire logic need_single_wr;
   wire logic store_fill;
   wire logic victim_pick;
   wire logic [cache_policy_pkg::INDEX_W-1:0] req_index;
   cache_policy_pkg::sys_cmd_t next_cmd;

   assign cur_attr = cache_algorithm_register[req_region * cache_policy_pkg::ATTR_W +:
      cache_policy_pkg::ATTR_W];
   assign attr_wb = cur_attr == cache_policy_pkg::ATTR_WB;
   assign attr_wt_alloc = cur_attr == cache_policy_pkg::ATTR_WT_ALLOC;
   assign attr_wt_noalloc = cur_attr == cache_policy_pkg::ATTR_WT_NOALLOC;
   // Unused codes fall back to uncached: never allocate what is not understood
   assign attr_uncached = !(attr_wb || attr_wt_alloc || attr_wt_noalloc);

   assign accept = (state == ST_IDLE) && req_valid;
   // Instruction fetches never store, so the store terms only see the data cache
   assign need_single_rd = !req_store && attr_uncached;
   assign need_block = !attr_uncached && !req_hit &&
      (!req_store || attr_wb || attr_wt_alloc);
   assign need_single_wr = req_store && (attr_uncached || (attr_wt_noalloc && !req_hit) ||
      (req_hit && !attr_wb));
   assign store_fill = req_store && need_block;
   assign req_index = req_addr[cache_policy_pkg::OFFS_W +: cache_policy_pkg::INDEX_W];

   assign next_cmd = need_block ? cache_policy_pkg::CMD_RD_BLOCK :
      need_single_rd ? cache_policy_pkg::CMD_RD_SINGLE :
      need_single_wr ? cache_policy_pkg::CMD_WR_SINGLE : cache_policy_pkg::CMD_NONE;

   // One victim selector per cache, each with its own set A lock
   victim_if vif_i (.clk(clk_sys), .rst(rst));
   victim_if vif_d (.clk(clk_sys), .rst(rst));

   assign vif_i.valid_a = tag_valid_a;
   assign vif_i.valid_b = tag_valid_b;
   assign vif_i.repl = tag_repl;
   assign vif_i.lock = instr_set_lock_bit;
   assign vif_d.valid_a = tag_valid_a;
   assign vif_d.valid_b = tag_valid_b;
   assign vif_d.repl = tag_repl;
   assign vif_d.lock = data_set_lock_bit;

   refill_victim_sel u_sel_i (
      .vif(vif_i.sel)
   );

   refill_victim_sel u_sel_d (
      .vif(vif_d.sel)
   );

   assign victim_pick = req_icache ? vif_i.way_b : vif_d.way_b;

   // Lock bits follow a status write on the next edge; software needs no
   // extra hazard slots beyond its own pipeline
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         data_set_lock_bit <= cache_policy_pkg::LOCK_RESET;
         instr_set_lock_bit <= cache_policy_pkg::LOCK_RESET;
      end
      else if (sr_we)
      begin
         data_set_lock_bit <= |(sr_wdata & cache_policy_pkg::SR_DLOCK_MASK);
         instr_set_lock_bit <= |(sr_wdata & cache_policy_pkg::SR_ILOCK_MASK);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         cache_algorithm_register <= cache_policy_pkg::CACHE_ALGORITHM_REGISTER_RESET;
      else if (cache_algorithm_register_we)
         cache_algorithm_register <= cache_algorithm_register_wdata;
   end

   // Sequencer
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
            if (req_valid)
               next_state = (next_cmd == cache_policy_pkg::CMD_NONE) ? ST_DONE : ST_ISSUE;
         ST_ISSUE:
            if (sys_req_ack)
               next_state = (sys_req_cmd == cache_policy_pkg::CMD_WR_SINGLE) ? ST_DONE : ST_WAIT;
         ST_WAIT:
            if (sys_resp_valid)
               next_state = (sys_req_cmd == cache_policy_pkg::CMD_RD_BLOCK) ? ST_FILL : ST_DONE;
         ST_FILL:
            next_state = pend_merge ? ST_MERGE : ST_DONE;
         ST_MERGE:
            next_state = pend_wt ? ST_ISSUE : ST_DONE;
         ST_DONE:
            next_state = ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // Captured request
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         sys_req_addr <= '0;
         sys_req_size <= '0;
         sys_req_wdata <= '0;
         fill_icache <= 1'b0;
         fill_index <= '0;
         cur_uncached <= 1'b0;
         victim_b <= 1'b0;
      end
      else if (accept)
      begin
         sys_req_addr <= req_addr;
         sys_req_size <= req_size;
         sys_req_wdata <= req_wdata;
         fill_icache <= req_icache;
         fill_index <= req_index;
         cur_uncached <= attr_uncached;
         victim_b <= victim_pick;
      end
   end

   // Pending store work after an allocating fill
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pend_merge <= 1'b0;
         pend_wt <= 1'b0;
      end
      else if (accept)
      begin
         pend_merge <= store_fill;
         pend_wt <= store_fill && attr_wt_alloc;
      end
      else if (state == ST_MERGE)
         pend_merge <= 1'b0;
   end

   // System interface request
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         sys_req_valid <= 1'b0;
         sys_req_cmd <= cache_policy_pkg::CMD_NONE;
      end
      else if (accept)
      begin
         sys_req_valid <= next_cmd != cache_policy_pkg::CMD_NONE;
         sys_req_cmd <= next_cmd;
      end
      else if (state == ST_MERGE && pend_wt)
      begin
         sys_req_valid <= 1'b1;
         sys_req_cmd <= cache_policy_pkg::CMD_WR_SINGLE;
      end
      else if (state == ST_ISSUE && sys_req_ack)
         sys_req_valid <= 1'b0;
   end

   // Tag write: the agent's state is not trusted, every fill is owned
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         fill_we <= 1'b0;
         fill_way_b <= 1'b0;
         fill_repl <= 1'b0;
         fill_state <= cache_policy_pkg::LINE_INVALID;
      end
      else
      begin
         fill_we <= state == ST_WAIT && sys_resp_valid && !cur_uncached &&
            sys_req_cmd == cache_policy_pkg::CMD_RD_BLOCK;
         if (state == ST_WAIT && sys_resp_valid)
         begin
            fill_way_b <= victim_b;
            fill_repl <= !victim_b;
            fill_state <= cache_policy_pkg::LINE_DIRTY_EXCL;
         end
      end
   end

   // Store data goes into the freshly filled line whatever the lock says;
   // locking only steers which line is replaced
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         store_merge_we <= 1'b0;
      else
         store_merge_we <= state == ST_FILL && pend_merge;
   end

   // Handshake with the pipeline; no snoop or external invalidate exists
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         req_ready <= 1'b1;
         done <= 1'b0;
         done_rdata <= '0;
      end
      else
      begin
         done <= state == ST_DONE;
         if (accept)
            req_ready <= 1'b0;
         else if (state == ST_DONE)
            req_ready <= 1'b1;
         if (state == ST_WAIT && sys_resp_valid &&
            sys_req_cmd == cache_policy_pkg::CMD_RD_SINGLE)
            done_rdata <= sys_resp_data;
      end
   end

   sequence s_fill_wt;
      fill_we && pend_wt;
   endsequence

   sequence s_merge_then_write;
      store_merge_we ##1 (sys_req_valid && sys_req_cmd == cache_policy_pkg::CMD_WR_SINGLE);
   endsequence

   a_uncached_single: assert property (@(posedge clk_sys) disable iff (rst)
      accept && attr_uncached |=> sys_req_valid &&
      (sys_req_cmd == cache_policy_pkg::CMD_RD_SINGLE ||
      sys_req_cmd == cache_policy_pkg::CMD_WR_SINGLE))
      else $error("uncached access not sent as single transfer");

   a_uncached_nofill: assert property (@(posedge clk_sys) disable iff (rst)
      fill_we |-> !cur_uncached)
      else $error("line allocated for uncached address");

   a_load_block_read: assert property (@(posedge clk_sys) disable iff (rst)
      accept && !req_store && !req_hit && !attr_uncached |=>
      sys_req_valid && sys_req_cmd == cache_policy_pkg::CMD_RD_BLOCK)
      else $error("cacheable load miss without block read");

   a_alloc_then_wt: assert property (@(posedge clk_sys) disable iff (rst)
      s_fill_wt |=> s_merge_then_write)
      else $error("write-allocate store not written through after fill");

   a_noalloc_write: assert property (@(posedge clk_sys) disable iff (rst)
      accept && req_store && !req_hit && attr_wt_noalloc |=>
      sys_req_cmd == cache_policy_pkg::CMD_WR_SINGLE ##1 !fill_we [*3])
      else $error("no-write-allocate store miss handled wrongly");

   a_lock_reset: assert property (@(posedge clk_sys)
      rst |=> !data_set_lock_bit && !instr_set_lock_bit)
      else $error("lock bit set after reset");

   a_lock_update: assert property (@(posedge clk_sys) disable iff (rst)
      sr_we |=> data_set_lock_bit == $past(|(sr_wdata & cache_policy_pkg::SR_DLOCK_MASK)) &&
      instr_set_lock_bit == $past(|(sr_wdata & cache_policy_pkg::SR_ILOCK_MASK)))
      else $error("lock bits did not follow status write");

   a_fill_dirty_excl: assert property (@(posedge clk_sys) disable iff (rst)
      fill_we |-> fill_state == cache_policy_pkg::LINE_DIRTY_EXCL && fill_repl == !fill_way_b)
      else $error("refilled line not dirty exclusive");

endmodule
`default_nettype wire

/* File: core/cache_policy_pkg.sv */
// Constants and types shared by the miss-policy block, the external agent model and the bench.
// Assumes one processor clock domain; all widths are fixed.
package cache_policy_pkg;

   // Geometry: 8KB per cache, two 4KB ways, 32-byte lines
   localparam int CACHE_BYTES = 8192;
   localparam int WAY_BYTES = 4096;
   localparam int LINE_BYTES = 32;
   localparam int WAYS = CACHE_BYTES / WAY_BYTES;
   localparam int OFFS_W = $clog2(LINE_BYTES);
   localparam int INDEX_W = $clog2(WAY_BYTES / LINE_BYTES);

   // Bus widths
   localparam int ADDR_W = 32;
   localparam int DATA_W = 64;
   localparam int SIZE_W = 3;
   localparam int SR_W = 32;

   // Cache algorithm register: one 3-bit attribute per region
   localparam int ATTR_W = 3;
   localparam int REGIONS = 8;
   localparam int REGION_W = $clog2(REGIONS);
   localparam int CACHE_ALGORITHM_REGISTER_W = REGIONS * ATTR_W;

   localparam logic [ATTR_W-1:0] ATTR_WT_NOALLOC = 3'h0;
   localparam logic [ATTR_W-1:0] ATTR_WT_ALLOC = 3'h1;
   localparam logic [ATTR_W-1:0] ATTR_UNCACHED = 3'h2;
   localparam logic [ATTR_W-1:0] ATTR_WB = 3'h3;
   localparam logic [CACHE_ALGORITHM_REGISTER_W-1:0] CACHE_ALGORITHM_REGISTER_RESET = {REGIONS{ATTR_UNCACHED}};

   // Lock bits inside the status register
   localparam logic [SR_W-1:0] SR_DLOCK_MASK = 32'h0010_0000;
   localparam logic [SR_W-1:0] SR_ILOCK_MASK = 32'h0008_0000;
   localparam logic LOCK_RESET = 1'b0;

   typedef enum logic [1:0] {CMD_NONE, CMD_RD_SINGLE, CMD_WR_SINGLE, CMD_RD_BLOCK} sys_cmd_t;
   typedef enum logic {LINE_INVALID, LINE_DIRTY_EXCL} line_state_t;

endpackage

/* File: core/victim_if.sv */
// Carrier between the miss-policy block and one refill victim selector.
// Assumes the owner drives clk and rst from the processor clock domain.
`timescale 1ns/1ps
`default_nettype none
interface victim_if (input wire logic clk, input wire logic rst);
   logic valid_a;
   logic valid_b;
   logic lock;
   logic repl;
   logic way_b;
   modport sel (input clk, input rst, input valid_a, input valid_b, input lock, input repl,
      output way_b);
   modport user (input way_b, output valid_a, output valid_b, output lock, output repl);
endinterface
`default_nettype wire

/* File: core/refill_victim_sel.sv */
// Refill victim choice for one two-way cache at the indexed pair of lines.
// Assumes valid, lock and replacement bits are stable for the cycle they are used.
`timescale 1ns/1ps
`default_nettype none
module refill_victim_sel (
   victim_if.sel vif
);

   // An empty set A is taken first, even when locked; then an empty set B;
   // a locked valid set A forces set B; otherwise the FIFO bit decides.
   wire logic pick_a_empty;
   wire logic pick_b_empty;
   wire logic pick_forced_b;

   assign pick_a_empty = !vif.valid_a;
   assign pick_b_empty = vif.valid_a && !vif.valid_b;
   assign pick_forced_b = vif.valid_a && vif.valid_b && vif.lock;
   assign vif.way_b = pick_a_empty ? 1'b0 :
      (pick_b_empty || pick_forced_b) ? 1'b1 : vif.repl;

   a_locked_set_safe: assert property (@(posedge vif.clk) disable iff (vif.rst)
      vif.lock && vif.valid_a |-> vif.way_b)
      else $error("valid line in locked set A chosen as victim");

   a_locked_goes_b: assert property (@(posedge vif.clk) disable iff (vif.rst)
      vif.lock && vif.valid_a && vif.valid_b |-> vif.way_b)
      else $error("locked full pair did not replace set B");

   a_empty_pair_a: assert property (@(posedge vif.clk) disable iff (vif.rst)
      !vif.valid_a && !vif.valid_b |-> !vif.way_b)
      else $error("empty pair did not refill set A");

   a_invalid_locked_a: assert property (@(posedge vif.clk) disable iff (vif.rst)
      vif.lock && !vif.valid_a |-> !vif.way_b)
      else $error("invalid line in locked set A not refilled");

   a_fifo_choice: assert property (@(posedge vif.clk) disable iff (vif.rst)
      vif.valid_a && vif.valid_b && !vif.lock |-> vif.way_b == vif.repl)
      else $error("replacement bit ignored on unlocked full pair");

endmodule
`default_nettype wire

/* File: bench/ext_agent.sv */
// External agent model answering single and block requests of the miss-policy block.
// Assumes one clock; stall sets the wait before every ack and every read response.
`timescale 1ns/1ps
`default_nettype none
module ext_agent (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Pacing from the bench
   input wire logic [3:0] stall,
   // Request side
   input wire logic sys_req_valid,
   input wire cache_policy_pkg::sys_cmd_t sys_req_cmd,
   input wire logic [cache_policy_pkg::ADDR_W-1:0] sys_req_addr,
   output logic sys_req_ack,
   // Response side
   output logic sys_resp_valid,
   output logic [cache_policy_pkg::DATA_W-1:0] sys_resp_data
);
   cache_policy_pkg::sys_cmd_t cmd;
   logic [cache_policy_pkg::ADDR_W-1:0] addr;

   task automatic pause;
      repeat (stall)
      begin
         @(posedge clk_sys);
         #5;
      end
   endtask

   initial
   begin
      sys_req_ack = 1'b0;
      sys_resp_valid = 1'b0;
      sys_resp_data = 64'h0;
      forever
      begin
         @(posedge clk_sys);
         if (!rst && sys_req_valid)
         begin
            cmd = sys_req_cmd;
            addr = sys_req_addr;
            #5;
            pause();
            sys_req_ack = 1'b1;
            @(posedge clk_sys);
            #5 sys_req_ack = 1'b0;
            if (cmd != cache_policy_pkg::CMD_WR_SINGLE)
            begin
               pause();
               sys_resp_valid = 1'b1;
               // No line state is returned; block data go to arrays outside
               sys_resp_data = {addr, ~addr};
               @(posedge clk_sys);
               #5 sys_resp_valid = 1'b0;
               // Released data must not look like a held value
               sys_resp_data = ~sys_resp_data;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the cache miss policy block.
// Assumes the external agent model beside it answers every system request.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int DLY = 5;
   localparam cache_policy_pkg::sys_cmd_t RD = cache_policy_pkg::CMD_RD_SINGLE;
   localparam cache_policy_pkg::sys_cmd_t WR = cache_policy_pkg::CMD_WR_SINGLE;
   localparam cache_policy_pkg::sys_cmd_t BLK = cache_policy_pkg::CMD_RD_BLOCK;
   // Regions 7..0 hold attributes 2,2,2,4,3,2,1,0
   localparam logic [23:0] CACHE_ALGORITHM_REGISTER_MIX = {3'h2, 3'h2, 3'h2, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
   // {lock, valid_a, valid_b, repl, expected way}
   localparam logic [4:0] VICTIM [7] = '{5'h12, 5'h19, 5'h1d, 5'h14, 5'h0c, 5'h0f, 5'h09};

   logic clk_sys, rst, sr_we, cache_algorithm_register_we, req_valid, req_icache, req_store, req_hit;
   logic tag_valid_a, tag_valid_b, tag_repl, req_ready, done, sys_req_valid, sys_req_ack;
   logic sys_resp_valid, fill_we, fill_icache, fill_way_b, fill_repl, store_merge_we;
   logic data_set_lock_bit, instr_set_lock_bit;
   logic [31:0] sr_wdata, req_addr, sys_req_addr, last_addr;
   logic [23:0] cache_algorithm_register_wdata, cache_algorithm_register, cache_algorithm_register_model;
   logic [2:0] req_region, req_size, sys_req_size, last_size;
   logic [63:0] req_wdata, done_rdata, sys_req_wdata, sys_resp_data, last_wdata;
   logic [6:0] fill_index;
   logic [3:0] stall;
   cache_policy_pkg::sys_cmd_t sys_req_cmd;
   cache_policy_pkg::line_state_t fill_state;
   logic [15:0] evq[$];
   int err_total = 0;
   int checks_done = 0;

   cache_miss_policy uut (.clk_sys, .rst, .sr_we, .sr_wdata, .cache_algorithm_register_we, .cache_algorithm_register_wdata,
      .data_set_lock_bit, .instr_set_lock_bit, .cache_algorithm_register, .req_valid,
      .req_icache, .req_store, .req_hit, .req_region, .req_addr, .req_size, .req_wdata,
      .tag_valid_a, .tag_valid_b, .tag_repl, .req_ready, .done, .done_rdata, .sys_req_valid,
      .sys_req_cmd, .sys_req_addr, .sys_req_size, .sys_req_wdata, .sys_req_ack,
      .sys_resp_valid, .sys_resp_data, .fill_we, .fill_icache, .fill_way_b, .fill_index,
      .fill_state, .fill_repl, .store_merge_we);

   ext_agent agent (.clk_sys, .rst, .stall, .sys_req_valid, .sys_req_cmd, .sys_req_addr,
      .sys_req_ack, .sys_resp_valid, .sys_resp_data);

   always #25 clk_sys = ~clk_sys;

   // Event log of one request, in the order the block produced them
   always @(posedge clk_sys)
   begin
      if (sys_req_valid && sys_req_ack)
      begin
         evq.push_back({4'h1, 10'h0, sys_req_cmd});
         last_addr = sys_req_addr;
         last_size = sys_req_size;
         last_wdata = sys_req_wdata;
      end
      if (fill_we)
         evq.push_back({4'h2, 1'h0, fill_icache, fill_way_b, fill_state, fill_repl, fill_index});
      if (store_merge_we)
         evq.push_back(16'h3000);
      if (done)
         evq.push_back(16'h4000);
   end

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test;
      $display("Checks %0d, errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic sr_write(input logic [31:0] v);
      sr_wdata = v;
      sr_we = 1'b1;
      @(posedge clk_sys);
      #DLY sr_we = 1'b0;
   endtask

   // One request; tw is {valid_a, valid_b, repl, expected way}
   task automatic run(input logic ic, input logic st, input logic hit, input logic [2:0] rg,
      input logic [31:0] a, input logic [3:0] tw);
      logic [15:0] q[$];
      logic [2:0] attr;
      logic unc;
      logic single;
      logic bus1;
      int n;
      attr = cache_algorithm_register_model[3*rg +: 3];
      unc = attr == cache_policy_pkg::ATTR_UNCACHED || attr[2];
      single = unc || (st && (hit || attr == cache_policy_pkg::ATTR_WT_NOALLOC));
      bus1 = single && !(st && hit && attr == cache_policy_pkg::ATTR_WB);
      if (bus1)
         q.push_back({4'h1, 10'h0, st ? WR : RD});
      else if (!single)
      begin
         q.push_back({4'h1, 10'h0, BLK});
         q.push_back({4'h2, 1'h0, ic, tw[0], cache_policy_pkg::LINE_DIRTY_EXCL, ~tw[0], a[11:5]});
         if (st)
            q.push_back(16'h3000);
         if (st && attr == cache_policy_pkg::ATTR_WT_ALLOC)
            q.push_back({4'h1, 10'h0, WR});
      end
      q.push_back(16'h4000);
      check("ready", req_ready, 1'b1);
      evq.delete();
      req_icache = ic;
      req_store = st;
      req_hit = hit;
      req_region = rg;
      req_addr = a;
      req_size = 3'h3;
      req_wdata = {~a, a};
      {tag_valid_a, tag_valid_b, tag_repl} = tw[3:1];
      req_valid = 1'b1;
      @(posedge clk_sys);
      #DLY req_valid = 1'b0;
      n = 0;
      while (done !== 1'b1)
      begin
         @(posedge clk_sys);
         #DLY;
         n++;
         if (n > 60)
         begin
            err_total++;
            $display("MISMATCH done expected 1 seen timeout");
            finish_test();
         end
      end
      check("ready at done", req_ready, 1'b1);
      if (!st && unc)
         check("uncached data", done_rdata, {a, ~a});
      if (bus1)
      begin
         check("sys addr", last_addr, a);
         check("sys size", last_size, 3'h3);
         if (st)
            check("sys wdata", last_wdata, {~a, a});
      end
      @(posedge clk_sys);
      #DLY;
      check("event count", evq.size(), q.size());
      foreach (q[i])
         if (i < evq.size())
            check("event", evq[i], q[i]);
   endtask

   initial
   begin
      {clk_sys, sr_we, cache_algorithm_register_we, req_valid, req_icache, req_store, req_hit} = 7'h0;
      {tag_valid_a, tag_valid_b, tag_repl} = 3'h0;
      {sr_wdata, cache_algorithm_register_wdata, req_region, req_addr, req_size, req_wdata} = '0;
      stall = 4'h0;
      rst = 1'b1;
      cache_algorithm_register_model = 24'h492492;
      repeat (4) @(posedge clk_sys);
      #DLY rst = 1'b0;
      check("data lock", data_set_lock_bit, 1'b0);
      check("instr lock", instr_set_lock_bit, 1'b0);
      check("cache_algorithm_register", cache_algorithm_register, 24'h492492);
      cache_algorithm_register_wdata = CACHE_ALGORITHM_REGISTER_MIX;
      cache_algorithm_register_we = 1'b1;
      @(posedge clk_sys);
      #DLY cache_algorithm_register_we = 1'b0;
      cache_algorithm_register_model = CACHE_ALGORITHM_REGISTER_MIX;
      check("cache_algorithm_register", cache_algorithm_register, CACHE_ALGORITHM_REGISTER_MIX);
      // Attribute codes 0 to 4, loads and store misses, prompt then slow agent
      for (int d = 0; d < 2; d++)
      begin
         stall = 4'(2 * d);
         for (int r = 0; r < 5; r++)
            for (int s = 0; s < 2; s++)
               run(d[0] & ~s[0], s[0], 1'b0, r[2:0], 32'h120 * r + 32'h20 * s + 32'h840 * d, 4'h0);
      end
      stall = 4'h1;
      run(1'b0, 1'b1, 1'b1, 3'h0, 32'h3000, 4'hc);
      run(1'b0, 1'b1, 1'b1, 3'h3, 32'h3020, 4'hc);
      stall = 4'h0;
      foreach (VICTIM[i])
      begin
         sr_write(VICTIM[i][4] ? 32'h0010_0000 : 32'h0);
         check("data lock", data_set_lock_bit, VICTIM[i][4]);
         run(1'b0, 1'b0, 1'b0, 3'h3, 32'h5000 + 32'h20 * i, VICTIM[i][3:0]);
      end
      sr_write(32'h0008_0000);
      check("instr lock", instr_set_lock_bit, 1'b1);
      check("data lock", data_set_lock_bit, 1'b0);
      run(1'b1, 1'b0, 1'b0, 3'h3, 32'h6000, 4'hd);
      run(1'b0, 1'b0, 1'b0, 3'h3, 32'h6020, 4'hc);
      sr_write(32'h0018_0000);
      check("data lock", data_set_lock_bit, 1'b1);
      run(1'b0, 1'b1, 1'b1, 3'h1, 32'h6040, 4'hc);
      rst = 1'b1;
      @(posedge clk_sys);
      #DLY rst = 1'b0;
      check("data lock", data_set_lock_bit, 1'b0);
      check("instr lock", instr_set_lock_bit, 1'b0);
      check("cache_algorithm_register", cache_algorithm_register, 24'h492492);
      finish_test();
   end
endmodule
`default_nettype wire
